// ===== rtl/asc_defines.svh
// Purpose: timing counts and pin constants for the static memory host port
// Assumes: 10 MHz clock, 100 ns period
// Notes: times in ns, cycle counts derived from them
`ifndef ASC_DEFINES_SVH
`define ASC_DEFINES_SVH
`define ASC_CLK_PERIOD_NS 100
`define ASC_ADDR_W 15
`define ASC_DATA_W 9
// least times round up to whole cycles, never below one
`define ASC_CYC_MIN(t) ((((t) + `ASC_CLK_PERIOD_NS - 1) / `ASC_CLK_PERIOD_NS) < 1 ? 1 : \
  (((t) + `ASC_CLK_PERIOD_NS - 1) / `ASC_CLK_PERIOD_NS))
`define ASC_WRITE_PULSE_NS 15
`define ASC_STROBE_TO_FLOAT_DELAY_NS 7
`define ASC_DATA_SETUP_TIME_NS 10
`define ASC_ACCESS_NS 20
`define ASC_CYCLE_NS 20
`define ASC_FLOAT_NS 9
`define ASC_WR_CYC `ASC_CYC_MIN(`ASC_STROBE_TO_FLOAT_DELAY_NS + `ASC_DATA_SETUP_TIME_NS)
`define ASC_RD_CYC `ASC_CYC_MIN(`ASC_ACCESS_NS)
`define ASC_TURN_CYC `ASC_CYC_MIN(`ASC_FLOAT_NS)
`define ASC_CNT_W 4
`endif

// ===== rtl/asc_pkg.sv
// Purpose: types for the static memory host port
// Assumes: nothing
// Notes: state codes binary
package asc_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_WSET = 3'b001,
    ST_WPUL = 3'b010,
    ST_WEND = 3'b011,
    ST_RSEL = 3'b100,
    ST_RTURN = 3'b101
  } asc_state_t;
endpackage

// ===== rtl/asc_cnt.sv
// Purpose: down counter timing the strobe, read and turnaround phases of a memory cycle
// Assumes: load has priority over counting
// Notes: o_zero high when count reaches zero
`timescale 1ns/1ps
`default_nettype none
`include "asc_defines.svh"
module asc_cnt (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_load,
  input wire logic [`ASC_CNT_W-1:0] i_value,
  output logic o_zero
);
  logic [`ASC_CNT_W-1:0] cnt_ff;
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cnt_ff <= '0;
    end else if (i_load) begin
      cnt_ff <= i_value;
    end else if (cnt_ff != '0) begin
      cnt_ff <= cnt_ff - 1'b1;
    end
  end
  assign o_zero = (cnt_ff == '0);
endmodule
`default_nettype wire

// ===== rtl/asc_host.sv
// Purpose: host controller for a 32K x 9 asynchronous static memory
// Assumes: one request at a time, taken when o_ready high
// Notes: reads end with one turnaround cycle before the bus is reused
`timescale 1ns/1ps
`default_nettype none
`include "asc_defines.svh"
module asc_host (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_req,
  input wire logic i_write,
  input wire logic [`ASC_ADDR_W-1:0] i_addr,
  input wire logic [`ASC_DATA_W-1:0] i_wdata,
  output logic o_ready,
  output logic o_rvalid,
  output logic [`ASC_DATA_W-1:0] o_rdata,
  output logic [`ASC_ADDR_W-1:0] o_word_address_15b,
  output logic o_select_low_active_n,
  output logic o_select_high_active,
  output logic o_write_strobe_n,
  output logic o_output_enable_n,
  input wire logic [`ASC_DATA_W-1:0] i_data_bus_9b,
  output logic [`ASC_DATA_W-1:0] o_data_bus_9b,
  output logic o_data_bus_9b_oe
);
  asc_pkg::asc_state_t state_ff, nxt_state;
  logic cnt_load;
  logic [`ASC_CNT_W-1:0] cnt_value;
  logic cnt_zero;
  logic sel_ff;
  logic we_n_ff;
  logic oe_n_ff;
  logic drive_ff;

  asc_cnt u_cnt (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_load(cnt_load),
    .i_value(cnt_value),
    .o_zero(cnt_zero)
  );

  assign o_ready = (state_ff == asc_pkg::ST_IDLE);

  always_comb begin
    nxt_state = state_ff;
    cnt_load = 1'b0;
    cnt_value = '0;
    case (state_ff)
      asc_pkg::ST_IDLE: begin
        if (i_req && i_write) begin
          nxt_state = asc_pkg::ST_WSET;
        end else if (i_req) begin
          nxt_state = asc_pkg::ST_RSEL;
          cnt_load = 1'b1;
          cnt_value = `ASC_CNT_W'(`ASC_RD_CYC);
        end
      end
      asc_pkg::ST_WSET: begin
        nxt_state = asc_pkg::ST_WPUL;
        cnt_load = 1'b1;
        cnt_value = `ASC_CNT_W'(`ASC_WR_CYC - 1);
      end
      asc_pkg::ST_WPUL: begin
        if (cnt_zero) begin
          nxt_state = asc_pkg::ST_WEND;
        end
      end
      asc_pkg::ST_WEND: begin
        nxt_state = asc_pkg::ST_IDLE;
      end
      asc_pkg::ST_RSEL: begin
        if (cnt_zero) begin
          nxt_state = asc_pkg::ST_RTURN;
          cnt_load = 1'b1;
          cnt_value = `ASC_CNT_W'(`ASC_TURN_CYC - 1);
        end
      end
      asc_pkg::ST_RTURN: begin
        if (cnt_zero) begin
          nxt_state = asc_pkg::ST_IDLE;
        end
      end
      default: begin
        nxt_state = asc_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_ff <= asc_pkg::ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // address and write data latched at request, stable through the cycle
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_word_address_15b <= '0;
      o_data_bus_9b <= '0;
    end else if (o_ready && i_req) begin
      o_word_address_15b <= i_addr;
      o_data_bus_9b <= i_wdata;
    end
  end

  // selects asserted with address; released one cycle after strobe rises in writes, with output enable in reads
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sel_ff <= 1'b0;
    end else if (o_ready && i_req) begin
      sel_ff <= 1'b1;
    end else if (nxt_state == asc_pkg::ST_IDLE || nxt_state == asc_pkg::ST_RTURN) begin
      sel_ff <= 1'b0;
    end
  end
  assign o_select_low_active_n = ~sel_ff;
  assign o_select_high_active = sel_ff;

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      we_n_ff <= 1'b1;
    end else begin
      we_n_ff <= (nxt_state != asc_pkg::ST_WPUL);
    end
  end
  assign o_write_strobe_n = we_n_ff;

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      oe_n_ff <= 1'b1;
    end else begin
      oe_n_ff <= (nxt_state != asc_pkg::ST_RSEL);
    end
  end
  assign o_output_enable_n = oe_n_ff;

  // bus driven only across writes, never with output enable low
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      drive_ff <= 1'b0;
    end else begin
      drive_ff <= (nxt_state == asc_pkg::ST_WSET || nxt_state == asc_pkg::ST_WPUL ||
                   nxt_state == asc_pkg::ST_WEND);
    end
  end
  assign o_data_bus_9b_oe = drive_ff;

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_rdata <= '0;
      o_rvalid <= 1'b0;
    end else begin
      o_rvalid <= 1'b0;
      if (state_ff == asc_pkg::ST_RSEL && cnt_zero) begin
        o_rdata <= i_data_bus_9b;
        o_rvalid <= 1'b1;
      end
    end
  end

  property p_no_contention;
    @(posedge i_clk) disable iff (!i_reset_n)
      o_data_bus_9b_oe |-> o_output_enable_n;
  endproperty
  a_no_contention: assert property (p_no_contention) else $error("bus driven with oe low");

  property p_strobe_high_in_read;
    @(posedge i_clk) disable iff (!i_reset_n)
      !o_output_enable_n |-> o_write_strobe_n;
  endproperty
  a_strobe_high_in_read: assert property (p_strobe_high_in_read) else $error("strobe low in read");

  property p_write_qualified;
    @(posedge i_clk) disable iff (!i_reset_n)
      !o_write_strobe_n |-> (!o_select_low_active_n && o_select_high_active && o_data_bus_9b_oe);
  endproperty
  a_write_qualified: assert property (p_write_qualified) else $error("strobe without select");

  property p_oe_off_in_write;
    @(posedge i_clk) disable iff (!i_reset_n)
      !o_write_strobe_n |-> o_output_enable_n;
  endproperty
  a_oe_off_in_write: assert property (p_oe_off_in_write) else $error("oe low in write");

  // strobe low run length, judged when the strobe rises
  logic [`ASC_CNT_W-1:0] low_cnt_ff;
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      low_cnt_ff <= '0;
    end else if (!o_write_strobe_n) begin
      low_cnt_ff <= low_cnt_ff + 1'b1;
    end else begin
      low_cnt_ff <= '0;
    end
  end

  property p_strobe_width;
    @(posedge i_clk) disable iff (!i_reset_n)
      $rose(o_write_strobe_n) |-> (low_cnt_ff >= `ASC_CNT_W'(`ASC_WR_CYC));
  endproperty
  a_strobe_width: assert property (p_strobe_width) else $error("strobe too short");

  property p_hold_after_end;
    @(posedge i_clk) disable iff (!i_reset_n)
      $rose(o_write_strobe_n) |-> (o_data_bus_9b_oe && $stable(o_data_bus_9b) && sel_ff);
  endproperty
  a_hold_after_end: assert property (p_hold_after_end) else $error("data not held");

  property p_sel_pair;
    @(posedge i_clk) disable iff (!i_reset_n)
      o_select_low_active_n != o_select_high_active;
  endproperty
  a_sel_pair: assert property (p_sel_pair) else $error("selects disagree");

  property p_addr_stable;
    @(posedge i_clk) disable iff (!i_reset_n)
      (sel_ff && $past(sel_ff)) |-> $stable(o_word_address_15b);
  endproperty
  a_addr_stable: assert property (p_addr_stable) else $error("address moved in cycle");

  property p_read_done;
    @(posedge i_clk) disable iff (!i_reset_n)
      $fell(o_output_enable_n) |-> ##[1:3] o_rvalid;
  endproperty
  a_read_done: assert property (p_read_done) else $error("read not answered");
endmodule
`default_nettype wire

// ===== tb/asc_sram_model.sv
// Purpose: behavioural 32K x 9 static memory on the far side of the host port
// Assumes: zero pin delays
// Notes: a write is stored when the select and strobe overlap ends
`timescale 1ns/1ps
`default_nettype none
module asc_sram_model (
  input wire logic [14:0] i_addr,
  input wire logic i_sel_n,
  input wire logic i_sel,
  input wire logic i_we_n,
  input wire logic i_oe_n,
  input wire logic [8:0] i_bus,
  output logic [8:0] o_data,
  output logic o_oe
);
  logic [8:0] mem [0:32767];
  wire logic sel = !i_sel_n && i_sel;
  wire logic wr = sel && !i_we_n;
  always @(negedge wr) mem[i_addr] = i_bus;
  assign o_oe = sel && i_we_n && !i_oe_n;
  assign o_data = o_oe ? mem[i_addr] : 9'h000;
endmodule
`default_nettype wire

// ===== tb/async_sram_32k_x9_port_tb_top.sv
// Purpose: self-checking bench for the static memory host port
// Assumes: inputs driven at the falling edge
// Notes: released bus shows the inverse of its last value
`timescale 1ns/1ps
`default_nettype none
`include "asc_defines.svh"
module async_sram_32k_x9_port_tb_top;
  logic i_clk = 1'b0;
  logic i_reset_n = 1'b0;
  logic i_req = 1'b0;
  logic i_write = 1'b0;
  logic [14:0] i_addr = 15'h0000;
  logic [8:0] i_wdata = 9'h000;
  logic o_ready, o_rvalid, sel_n, sel, we_n, oe_n, h_oe, d_oe;
  logic [8:0] o_rdata, h_d, d_d;
  logic [8:0] last = 9'h000;
  logic [14:0] o_addr;
  wire logic [8:0] bus = h_oe ? h_d : (d_oe ? d_d : ~last);
  int fails = 0;
  int n_compared = 0;
  always #(`ASC_CLK_PERIOD_NS / 2) i_clk = ~i_clk;
  asc_host i_dut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_req(i_req), .i_write(i_write),
    .i_addr(i_addr), .i_wdata(i_wdata), .o_ready(o_ready), .o_rvalid(o_rvalid),
    .o_rdata(o_rdata), .o_word_address_15b(o_addr), .o_select_low_active_n(sel_n),
    .o_select_high_active(sel), .o_write_strobe_n(we_n), .o_output_enable_n(oe_n),
    .i_data_bus_9b(bus), .o_data_bus_9b(h_d), .o_data_bus_9b_oe(h_oe));
  asc_sram_model i_mem (.i_addr(o_addr), .i_sel_n(sel_n), .i_sel(sel), .i_we_n(we_n),
    .i_oe_n(oe_n), .i_bus(bus), .o_data(d_d), .o_oe(d_oe));
  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  always @(negedge i_clk) begin
    if (h_oe === 1'b1 && d_oe === 1'b1) check(9'h001, 9'h000);
    if (h_oe === 1'b1 || d_oe === 1'b1) last <= bus;
  end
  task automatic do_write(input logic [14:0] a, input logic [8:0] d);
    int lo;
    int bad;
    int n;
    lo = 0;
    bad = 0;
    n = 0;
    i_req = 1'b1;
    i_write = 1'b1;
    i_addr = a;
    i_wdata = d;
    @(negedge i_clk);
    i_req = 1'b0;
    while (!(o_ready === 1'b1 && lo > 0) && n < 12) begin
      if (we_n === 1'b0) begin
        lo++;
        if (sel_n !== 1'b0 || sel !== 1'b1 || h_d !== d || h_oe !== 1'b1 || o_addr !== a) bad++;
      end
      if (oe_n !== 1'b1) bad++;
      @(negedge i_clk);
      n++;
    end
    check(9'(lo), 9'(`ASC_WR_CYC));
    check(9'(bad), 9'h000);
  endtask
  task automatic do_read(input logic [14:0] a, input logic [8:0] exp);
    int bad;
    int n;
    bad = 0;
    n = 0;
    i_req = 1'b1;
    i_write = 1'b0;
    i_addr = a;
    @(negedge i_clk);
    i_req = 1'b0;
    while (o_rvalid !== 1'b1 && n < 12) begin
      if (we_n !== 1'b1 || h_oe !== 1'b0 || (sel_n === 1'b0 && o_addr !== a)) bad++;
      @(negedge i_clk);
      n++;
    end
    check(o_rdata, exp);
    check(9'(bad), 9'h000);
    while (o_ready !== 1'b1 && n < 12) begin
      @(negedge i_clk);
      n++;
    end
  endtask
  task automatic t_reset();
    check({4'h0, sel_n, sel, we_n, oe_n, h_oe}, 9'h016);
    check({8'h00, o_ready}, 9'h001);
    $display("test reset done");
  endtask
  task automatic t_edges();
    do_write(15'h0000, 9'h1FF);
    do_write(15'h7FFF, 9'h000);
    do_read(15'h0000, 9'h1FF);
    do_read(15'h7FFF, 9'h000);
    do_write(15'h0000, 9'h0A5);
    do_read(15'h0000, 9'h0A5);
    $display("test edges done");
  endtask
  task automatic t_walk();
    for (int i = 0; i < 15; i++) do_write(15'(1 << i), 9'(i * 37 + 1));
    for (int i = 14; i >= 0; i--) do_read(15'(1 << i), 9'(i * 37 + 1));
    $display("test walk done");
  endtask
  task automatic summarize();
    $display("compared=%0d fails=%0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (20) @(negedge i_clk);
    i_reset_n = 1'b1;
    @(negedge i_clk);
    t_reset();
    t_edges();
    t_walk();
    summarize();
  end
  initial begin
    #(`ASC_CLK_PERIOD_NS * 2000);
    fails++;
    summarize();
  end
endmodule
`default_nettype wire
